// [hdl/cmps_seq.sv]
// Clock mode, power mode and reset sequencer with a classic Wishbone slave.
// Operation
// - Fast clock selected as system clock when select bit is one.
// - Instruction clock is system clock divided by two or four.
// - After reset, run fast or slow per startup configuration.
// - Mode field 10b enters standby, 01b enters halt.
// - Halt entry clears powerdown_n, sets watchdog_expired_n, clears watchdog.
// - Fast clock stop bit stops fast oscillator in slow and fast modes alike.
// - Slow clock feeds timer0 when routing bit and configuration agree in fast run.
// - Standby stops execution; slow clock and enabled timers keep running.
// - Standby exits on timer, watchdog, port_b change or external edge.
// - Halt stops execution, timers, peripherals and both oscillators.
// - Halt exits only on watchdog, port_b change or external edge.
// - After wake-up resume fast or slow per select bit.
// - Halt settling is 512 cycles with crystal modes, else 16.
// - Standby wake-up applies no settling delay.
// - Wake-up vectors to 0x008 when interrupts were enabled, else continues.
// - Stop bit change with halt entry accepted; avoid clock switch with sleep.
// - Reset on power-on, low supply, reset pin low or watchdog reset.
// - Reset loads defined values; unknown-valued registers keep contents.
// - Power-on/low supply set both flags; pin reset sets both only from halt.
// - Watchdog reset clears expired flag; powerdown cleared in halt, else set.
// - After release wait power-up time then 16 fast oscillator cycles.
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
module cmps_seq
  import cmps_pkg::*;
#(
  parameter int PWRUP_CYCLES = cmps_pkg::PWRUP_CYC
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Reset sources.
  input  wire logic             por_i,
  input  wire logic             low_supply_reset_i,
  input  wire logic             ext_reset_n_pin_i,
  // Core side.
  input  wire logic             sleep_op_i,
  input  wire logic             clrwdt_op_i,
  input  wire logic             global_irq_enable_i,
  input  wire logic             insn_boundary_i,
  input  wire logic             fast_ready_i,
  input  wire cmps_pkg::cm_cfg_t cfg_i,
  input  wire cmps_pkg::cm_wake_t wake_i,
  // Wishbone slave.
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o,
  // Clock and power controls.
  output logic                  fast_osc_en_o,
  output logic                  slow_osc_en_o,
  output logic                  sys_clk_fast_o,
  output logic                  inst_div4_o,
  output logic                  cpu_run_o,
  output logic                  cpu_reset_o,
  output logic                  periph_en_o,
  output logic [2:0]            timer_en_o,
  output logic                  t0_slow_clk_o,
  output logic                  wdt_clear_o,
  output logic                  wake_vector_o,
  output logic                  wake_next_o,
  output logic                  watchdog_expired_n_o,
  output logic                  powerdown_n_o
);
  import cmps_pkg::*;

  cm_state_t   state_r;
  logic [4:0]  clkctl_r;
  logic [2:0]  timer_on_r;
  logic        gie_sleep_r;
  logic [CNT_W-1:0] cnt_r;
  logic        ostwait_r;
  logic        pin_s1_r;
  logic        pin_s2_r;
  logic        rst_evt;
  logic        wr_stb;
  logic        rd_stb;
  logic        halt_req;
  logic        stby_req;
  logic        wake_stby;
  logic        wake_halt;
  logic        xtal;

  assign wr_stb = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  assign rd_stb = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  assign xtal   = cfg_i.fast_crystal_osc || cfg_i.mid_crystal_osc || cfg_i.watch_crystal_osc;
  assign stby_req = wr_stb && (wb_adr_i == ADR_CLKCTL)
                    && (wb_dat_i[CC_MODE+1:CC_MODE] == MODE_STANDBY);
  assign halt_req = (state_r == CM_RUN) && (sleep_op_i || (wr_stb && (wb_adr_i == ADR_CLKCTL)
                    && (wb_dat_i[CC_MODE+1:CC_MODE] == MODE_HALT)));
  assign wake_stby = (|wake_i.timer_wrap) || wake_i.wdt_timeout || wake_i.portb_change
                     || wake_i.ext_edge;
  assign wake_halt = wake_i.wdt_timeout || wake_i.portb_change || wake_i.ext_edge;

  // Reset pin synchroniser.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      pin_s1_r <= ext_reset_n_pin_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign rst_evt = por_i || low_supply_reset_i || !pin_s2_r || wake_i.wdt_reset;

  // Operating mode sequencer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r   <= CM_RESET;
      cnt_r     <= '0;
      ostwait_r <= 1'b0;
    end else if (rst_evt) begin
      state_r   <= CM_RESET;
      cnt_r     <= '0;
      ostwait_r <= 1'b0;
    end else begin
      case (state_r)
        CM_RESET: begin
          if (!ostwait_r) begin
            if (cnt_r >= CNT_W'(PWRUP_CYCLES - 1)) begin
              ostwait_r <= 1'b1;
              cnt_r     <= '0;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end else if (fast_ready_i) begin
            if (cnt_r >= CNT_W'(OST_CYC - 1)) begin
              state_r <= CM_RUN;
              cnt_r   <= '0;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
        end
        CM_RUN: begin
          if (halt_req) begin
            state_r <= CM_HALT;
          end else if (stby_req) begin
            state_r <= CM_STANDBY;
          end
        end
        CM_STANDBY: begin
          if (wake_stby) begin
            state_r <= CM_RUN;
          end
        end
        CM_HALT: begin
          if (wake_halt) begin
            state_r <= CM_SETTLE;
            cnt_r   <= '0;
          end
        end
        CM_SETTLE: begin
          if (cnt_r >= (xtal ? CNT_W'(WAKE_XT_CYC - 1) : CNT_W'(WAKE_RC_CYC - 1))) begin
            state_r <= CM_RUN;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: state_r <= CM_RESET;
      endcase
    end
  end

  // Clock control register; mode field is write-only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clkctl_r   <= CLKCTL_RST;
      timer_on_r <= '0;
    end else if (rst_evt || (state_r == CM_RESET)) begin
      clkctl_r   <= {4'h0, cfg_i.start_fast};
      timer_on_r <= '0;
    end else if (wr_stb && wb_adr_i == ADR_CLKCTL) begin
      // Stop bit; accepted with halt entry.
      clkctl_r <= {wb_dat_i[CC_T0LCK], 2'b00, wb_dat_i[CC_STOP], wb_dat_i[CC_SEL]};
    end else if (wr_stb && wb_adr_i == ADR_TIMERS) begin
      timer_on_r <= wb_dat_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watchdog_expired_n_o <= 1'b1;
      powerdown_n_o        <= 1'b1;
    end else if (por_i || low_supply_reset_i) begin
      watchdog_expired_n_o <= 1'b1;
      powerdown_n_o        <= 1'b1;
    end else if (wake_i.wdt_reset) begin
      watchdog_expired_n_o <= 1'b0;
      powerdown_n_o        <= !(state_r == CM_HALT);
    end else if (!pin_s2_r) begin
      if (state_r == CM_HALT) begin
        watchdog_expired_n_o <= 1'b1;
        powerdown_n_o        <= 1'b1;
      end
    end else if (halt_req) begin
      watchdog_expired_n_o <= 1'b1;
      powerdown_n_o        <= 1'b0;
    end else if (clrwdt_op_i) begin
      watchdog_expired_n_o <= 1'b1;
      powerdown_n_o        <= 1'b1;
    end
  end

  // Remember interrupt enable at sleep entry and pulse the wake action.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gie_sleep_r   <= 1'b0;
      wake_vector_o <= 1'b0;
      wake_next_o   <= 1'b0;
    end else begin
      if (halt_req || (state_r == CM_RUN && stby_req)) begin
        gie_sleep_r <= global_irq_enable_i;
      end
      wake_vector_o <= 1'b0;
      wake_next_o   <= 1'b0;
      if (!rst_evt && ((state_r == CM_STANDBY && wake_stby)
          || (state_r == CM_SETTLE && state_r != CM_RUN
              && cnt_r >= (xtal ? CNT_W'(WAKE_XT_CYC - 1) : CNT_W'(WAKE_RC_CYC - 1))))) begin
        wake_vector_o <= gie_sleep_r;
        wake_next_o   <= !gie_sleep_r;
      end
    end
  end

  // Clock and power outputs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_osc_en_o  <= 1'b1;
      slow_osc_en_o  <= 1'b1;
      sys_clk_fast_o <= 1'b1;
      inst_div4_o    <= 1'b0;
      cpu_run_o      <= 1'b0;
      cpu_reset_o    <= 1'b1;
      periph_en_o    <= 1'b0;
      timer_en_o     <= '0;
      t0_slow_clk_o  <= 1'b0;
      wdt_clear_o    <= 1'b0;
    end else begin
      // Halt and reset turn both oscillators off or hold them.
      fast_osc_en_o <= (state_r == CM_RESET) ||
                       (state_r != CM_HALT && !clkctl_r[CC_STOP]);
      slow_osc_en_o <= (state_r != CM_HALT);
      // Source follows select bit at boundaries while running, at any time otherwise.
      if (state_r != CM_RUN || insn_boundary_i) begin
        sys_clk_fast_o <= clkctl_r[CC_SEL];
      end
      inst_div4_o  <= cfg_i.div4;
      cpu_run_o    <= (state_r == CM_RUN) && !halt_req && !stby_req && !rst_evt;
      cpu_reset_o  <= (state_r == CM_RESET) || rst_evt;
      periph_en_o  <= (state_r == CM_RUN);
      timer_en_o   <= (state_r == CM_RUN || state_r == CM_STANDBY) ? timer_on_r : 3'h0;
      t0_slow_clk_o <= clkctl_r[CC_T0LCK] && cfg_i.t0_slow_src && clkctl_r[CC_SEL];
      wdt_clear_o  <= halt_req || clrwdt_op_i;
    end
  end

  // Wishbone answer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= '0;
      if (rd_stb) begin
        if (wb_adr_i == ADR_CLKCTL) begin
          wb_dat_o <= {27'h0, clkctl_r};
        end else if (wb_adr_i == ADR_STATUS) begin
          wb_dat_o <= {27'h0, watchdog_expired_n_o, powerdown_n_o, 3'h0};
        end else if (wb_adr_i == ADR_CONFIG) begin
          wb_dat_o <= {26'h0, state_r, gie_sleep_r};
        end else if (wb_adr_i == ADR_TIMERS) begin
          wb_dat_o <= {29'h0, timer_on_r};
        end
      end
    end
  end

  property settle_len_p;
    @(posedge clk_i) disable iff (rst_i)
      (state_r == CM_HALT && wake_halt && !rst_evt && !xtal) |=>
        (state_r == CM_SETTLE) [*8];
  endproperty
  settle_len_a: assert property (settle_len_p) else $error("Halt settle too short.");

  halt_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (halt_req && !rst_evt && !clrwdt_op_i) |=> (!powerdown_n_o && watchdog_expired_n_o))
    else $error("Halt entry flags wrong.");

  stby_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == CM_STANDBY && wake_stby && !rst_evt) |=> state_r == CM_RUN)
    else $error("Standby wake delayed.");

  halt_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == CM_HALT && !wake_halt && !rst_evt) |=> state_r == CM_HALT)
    else $error("Halt left without source.");

  halt_osc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == CM_HALT) [*2] |-> (!slow_osc_en_o && !fast_osc_en_o && !cpu_run_o))
    else $error("Oscillator on in halt.");

  wdt_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wake_i.wdt_reset && !por_i && !low_supply_reset_i) |=>
      (!watchdog_expired_n_o && powerdown_n_o == !($past(state_r) == CM_HALT)))
    else $error("Watchdog reset flags wrong.");

  rst_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rst_evt |=> (cpu_reset_o && !cpu_run_o))
    else $error("Reset event missed.");

  stby_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == CM_STANDBY) [*2] |-> (!cpu_run_o && slow_osc_en_o))
    else $error("Standby executing.");
endmodule

// [hdl/cmps_pkg.sv]
// Package with constants and carrier types for the clock mode power sequencer.
package cmps_pkg;
  localparam logic [7:0] ADR_CLKCTL   = 8'h00;
  localparam logic [7:0] ADR_STATUS   = 8'h04;
  localparam logic [7:0] ADR_CONFIG   = 8'h08;
  localparam logic [7:0] ADR_TIMERS   = 8'h0C;
  localparam logic [7:0] ADR_EVENTS   = 8'h10;
  localparam int CC_SEL   = 0;
  localparam int CC_STOP  = 1;
  localparam int CC_MODE  = 2;
  localparam int CC_T0LCK = 4;
  localparam int ST_PD    = 3;
  localparam int ST_TO    = 4;
  localparam logic [1:0] MODE_STANDBY = 2'b10;
  localparam logic [1:0] MODE_HALT    = 2'b01;
  localparam logic [4:0] CLKCTL_RST   = 5'h01;
  localparam int CLK_MHZ        = 40;
  localparam int PWRUP_US       = 140;
  localparam int PWRUP_CYC      = PWRUP_US * CLK_MHZ;
  localparam int OST_CYC        = 16;
  localparam int WAKE_XT_CYC    = 512;
  localparam int WAKE_RC_CYC    = 16;
  localparam logic [11:0] VEC_IRQ = 12'h008;
  localparam int CNT_W          = 20;

  typedef enum logic [4:0] {
    CM_RESET   = 5'b00001,
    CM_RUN     = 5'b00010,
    CM_STANDBY = 5'b00100,
    CM_HALT    = 5'b01000,
    CM_SETTLE  = 5'b10000
  } cm_state_t;

  typedef struct packed {
    logic       wdt_timeout;
    logic       wdt_reset;
    logic       portb_change;
    logic       ext_edge;
    logic [2:0] timer_wrap;
  } cm_wake_t;

  typedef struct packed {
    logic       fast_crystal_osc;
    logic       mid_crystal_osc;
    logic       watch_crystal_osc;
    logic       div4;
    logic       start_fast;
    logic       t0_slow_src;
  } cm_cfg_t;
endpackage

// [dv/cmps_far.sv]
// Behavioural oscillator and core model facing the sequencer.
`timescale 1ns/100ps
module cmps_far (
  // Clock.
  input  wire logic clk_i,
  // From the sequencer.
  input  wire logic fast_osc_en_i,
  input  wire logic run_i,
  input  wire logic div4_i,
  // To the sequencer.
  output logic      fast_ready_o,
  output logic      boundary_o
);
  logic [1:0] rdy_r;
  logic [1:0] ph_r;
  always_ff @(posedge clk_i) begin
    rdy_r <= fast_osc_en_i ? {rdy_r[0], 1'b1} : 2'h0;
  end
  assign fast_ready_o = rdy_r[1];
  always_ff @(posedge clk_i) begin
    ph_r <= run_i ? ph_r + 2'h1 : 2'h0;
  end
  assign boundary_o = run_i & (div4_i ? ph_r == 2'h3 : ph_r[0]);
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the clock mode power sequencer.
`timescale 1ns/100ps
module tb_top;
  import cmps_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i, por, lsr, pin_n, slp, global_irq_enable, cyc, stb, we, fr, bd, ack;
  logic        fo, so, sf, d4, run, pe, t0s, wv, wn, to_n, pd_n, crst, wclr;
  logic [2:0]  ten;
  logic [7:0]  adr, r;
  logic [31:0] dat, rdat;
  logic [1:0]  p;
  cm_cfg_t     cfg;
  cm_wake_t    wk;
  logic [31:0] exq[$];
  int          n_fail = 0, cmp_count = 0, cyc_n = 0, n;
  int          ks[7] = '{3, 0, 3, 2, 2, 3, 1};
  logic [1:0]  ex[7] = '{2'h0, 2'h3, 2'h1, 2'h1, 2'h3, 2'h1, 2'h3};
  always #12.5 clk_i = ~clk_i;
  cmps_seq #(.PWRUP_CYCLES(20)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por), .low_supply_reset_i(lsr),
    .ext_reset_n_pin_i(pin_n), .sleep_op_i(slp), .clrwdt_op_i(1'b0),
    .global_irq_enable_i(global_irq_enable), .insn_boundary_i(bd), .fast_ready_i(fr), .cfg_i(cfg),
    .wake_i(wk), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fast_osc_en_o(fo), .slow_osc_en_o(so), .sys_clk_fast_o(sf), .inst_div4_o(d4),
    .cpu_run_o(run), .cpu_reset_o(crst), .periph_en_o(pe), .timer_en_o(ten),
    .t0_slow_clk_o(t0s), .wdt_clear_o(wclr), .wake_vector_o(wv), .wake_next_o(wn),
    .watchdog_expired_n_o(to_n), .powerdown_n_o(pd_n));
  cmps_far far (.clk_i(clk_i), .fast_osc_en_i(fo), .run_i(run), .div4_i(d4),
    .fast_ready_o(fr), .boundary_o(bd));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    if (!w) exq.push_back(d);
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wt(input logic v);
    while (run !== v) @(posedge clk_i);
  endtask
  task automatic ev(input cm_wake_t w);
    @(posedge clk_i);
    wk <= w;
    @(posedge clk_i);
    wk <= '0;
  endtask
  task automatic nap();
    @(posedge clk_i);
    slp <= 1'b1;
    @(posedge clk_i);
    slp <= 1'b0;
    @(posedge clk_i);
    chk(wclr, 1);
    repeat (2) @(posedge clk_i);
  endtask
  task automatic wake(input cm_wake_t w);
    ev(w);
    n = 0;
    p = 2'h0;
    do begin
      @(posedge clk_i);
      n++;
      p = p | {wv, wn};
    end while (run !== 1'b1 && n < 700);
  endtask
  task automatic hit(input int k);
    @(posedge clk_i);
    por <= (k == 0);
    lsr <= (k == 1);
    pin_n <= (k != 2);
    wk.wdt_reset <= (k == 3);
    @(posedge clk_i);
    wk <= '0;
    repeat (2) @(posedge clk_i);
    por <= 1'b0;
    lsr <= 1'b0;
    pin_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(crst, 1);
    wt(0);
    wt(1);
  endtask
  // Read answers are compared with the oldest expectation.
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) chk(rdat, exq.pop_front());
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 12000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    {rst_i, por, lsr, pin_n, slp, global_irq_enable, cyc, stb, we} = 9'h120;
    {adr, dat, wk, r, cfg} = {8'h00, 32'h0, 7'h00, 8'h29, 6'h07};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wt(1);
    chk({sf, d4, to_n, pd_n}, 4'hF);
    cfg.div4 <= 1'b0;
    wb(0, ADR_CLKCTL, 32'h1);
    wb(0, ADR_STATUS, 32'h18);
    wb(0, 8'h40, 32'h0);
    r = lfsr(r);
    wb(1, ADR_TIMERS, {29'h0, r[2:0]});
    wb(0, ADR_TIMERS, {29'h0, r[2:0]});
    wb(1, ADR_CLKCTL, 32'h11);
    repeat (6) @(posedge clk_i);
    chk(t0s, 1);
    wb(1, ADR_CLKCTL, 32'h0);
    repeat (6) @(posedge clk_i);
    chk({sf, fo, d4}, 3'b010);
    wb(1, ADR_CLKCTL, 32'h2);
    repeat (3) @(posedge clk_i);
    chk(fo, 0);
    wb(1, ADR_CLKCTL, 32'hA);
    repeat (3) @(posedge clk_i);
    chk({run, so, ten}, {2'b01, r[2:0]});
    wake(7'h01);
    chk({n <= 3, p, sf}, 4'b1010);
    wb(1, ADR_CLKCTL, 32'h0);
    wb(1, ADR_CLKCTL, 32'h1);
    global_irq_enable <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      cfg.mid_crystal_osc <= (i == 2);
      if (i == 1) wb(1, ADR_CLKCTL, 32'h5);
      else nap();
      repeat (3) @(posedge clk_i);
      chk({run, fo, so, pe, ten, to_n, pd_n}, 9'h002);
      ev(7'h07);
      repeat (30) @(posedge clk_i);
      chk(run, 0);
      wake(i == 0 ? 7'h40 : (i == 1 ? 7'h10 : 7'h08));
      chk(n >= (i == 2 ? 512 : 16) && n <= (i == 2 ? 516 : 20), 1);
      chk({p, sf}, 3'b101);
    end
    for (int i = 0; i < 7; i++) begin
      cfg.start_fast <= (i != 6);
      if (i == 0 || i == 4) nap();
      hit(ks[i]);
      chk({crst, sf, to_n, pd_n}, {1'b0, i != 6, ex[i]});
    end
    finish_test();
  end
endmodule
